// File: core/ir_endec_params.svh
`ifndef IR_ENDEC_PARAMS_SVH
`define IR_ENDEC_PARAMS_SVH

// ----------------------------------------
// bit timing on the 16x clock
// ----------------------------------------
`define TICKS_PER_BIT 16
`define PULSE_TICKS 3
`define START_BAUD 9600
`define MAX_BAUD 115200
`define TICK_HZ (`START_BAUD * `TICKS_PER_BIT)
`define CLK_HZ 100000000
`define FIXED_PULSE_NS 1600
`define FIXED_PULSE_CYC ((`FIXED_PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define TICK_DIV (`CLK_HZ / `TICK_HZ)
`define FIFO_DEPTH 32

`endif

// File: core/ir_endec_pkg.sv
package ir_endec_pkg;
	// encoder states
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_PULSE = 2'b01,
		TX_REST = 2'b10
	} tx_state_t;
endpackage

// File: core/bit_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// ----------------------------------------
	// flags
	// ----------------------------------------
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// storage and pointers; push on full is refused by in_ready
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// File: core/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int DIV = 651
) (
	input wire logic clk,
	input wire logic nrst,
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt;

	// one-cycle enable every DIV clocks; rate error is the rounding of DIV
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt == CW'(DIV - 1));
			cnt <= (cnt == CW'(DIV - 1)) ? '0 : cnt + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: core/infrared_pulse_endec.sv
// Operation
// R1: encoder shortens NRZ bits to pulses; decoder stretches them back.
// R2: transmitted pulse lasts three of sixteen 16x ticks.
// R3: received pulse becomes a sixteen-tick output bit.
// R4: all timing derives from the 16x baud tick, sixteen per bit; the fixed pulse of R9 is counted in clk cycles (FIXED_PULSE_CYC) instead.
// R5: link starts at 9.6 Kb/s with 3/16 pulses.
// R6: start-up-only codec uses a 153600 Hz tick.
// R7: ends share frequency; no phase lock between them is needed.
// R8: codec supports rates up to 115.2 Kb/s only.
// R9: below 115.2 Kb/s a fixed 1.6 us pulse may be used.
// R10: every received pulse is one separate bit event.
// R11: host programs faster rates through spare handshake lines; here the rate is set only by the TICK_DIV parameter.
// R12: pulse only for zero bits; decoded pulse gives zero bit.
// R13: pulse starts at the zero bit start, counted in ticks.
`timescale 1ns/10ps
`default_nettype none
`include "ir_endec_params.svh"
module infrared_pulse_endec
	import ir_endec_pkg::*;
#(
	parameter int TICK_DIV = `TICK_DIV,
	parameter int TICKS_PER_BIT = `TICKS_PER_BIT,
	parameter int PULSE_TICKS = `PULSE_TICKS,
	parameter int FIXED_PULSE_CYC = `FIXED_PULSE_CYC,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic tx_bit,
	input wire logic fixed_pulse,
	output logic light_pulse_out,
	input wire logic light_pulse_in,
	output logic rx_nrz,
	output logic rx_valid,
	output logic rx_bit
);
	localparam int TW = $clog2(TICKS_PER_BIT + 1);
	localparam int FW = $clog2(FIXED_PULSE_CYC + 1);

	// ----------------------------------------
	// 16x tick
	// ----------------------------------------
	logic tick;

	// default divide gives 153600 Hz, the start-up rate; R4 R5 R6
	tick_divider #(.DIV(TICK_DIV)) u_div (
		.clk(clk),
		.nrst(nrst),
		.tick(tick)
	);
	// faster rates (R8 limit, R11 programming) come from a smaller TICK_DIV

	// ----------------------------------------
	// transmit buffer
	// ----------------------------------------
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_bit;
	logic fifo_pop;
	logic tx_take;

	// only a write seen with tx_ready high reaches the buffer
	assign tx_take = tx_valid && tx_ready;

	bit_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(tx_take),
		.in_ready(fifo_in_ready),
		.in_data(tx_bit),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_bit)
	);

	// registered ready drops for a cycle after each take, so it never
	// promises a slot that the last write has just filled
	logic tx_room;
	assign tx_room = fifo_in_ready && !tx_take;

	// ----------------------------------------
	// encoder
	// ----------------------------------------
	tx_state_t tx_state;
	tx_state_t next_tx_state;
	logic [TW-1:0] tx_ticks;
	logic [FW-1:0] fix_cnt;
	logic fix_mode;

	// a new bit starts on a tick once the previous one has run its 16 ticks
	wire bit_start = tick && fifo_out_valid &&
		(tx_state == TX_IDLE ||
		(tx_state != TX_IDLE && tx_ticks == TW'(TICKS_PER_BIT - 1)));
	wire bit_end = tick && tx_state != TX_IDLE &&
		tx_ticks == TW'(TICKS_PER_BIT - 1);
	wire ratio_done = tick && tx_ticks == TW'(PULSE_TICKS - 1); // R2
	wire fixed_done = fix_cnt == FW'(FIXED_PULSE_CYC - 1); // R9
	wire pulse_done = fix_mode ? fixed_done : ratio_done;
	assign fifo_pop = bit_start;

	// encoder next-state
	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			TX_IDLE: begin
				if (bit_start) begin
					next_tx_state = fifo_out_bit ? TX_REST : TX_PULSE; // R12
				end
			end
			TX_PULSE: begin
				if (bit_start) begin
					next_tx_state = fifo_out_bit ? TX_REST : TX_PULSE;
				end else if (bit_end) begin
					next_tx_state = TX_IDLE;
				end else if (pulse_done) begin
					next_tx_state = TX_REST;
				end
			end
			TX_REST: begin
				if (bit_start) begin
					next_tx_state = fifo_out_bit ? TX_REST : TX_PULSE;
				end else if (bit_end) begin
					next_tx_state = TX_IDLE;
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
			end
		endcase
	end

	// tick count within the bit, reset at each bit start; R13
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_state <= TX_IDLE;
			tx_ticks <= '0;
		end else begin
			tx_state <= next_tx_state;
			if (bit_start) begin
				tx_ticks <= '0;
			end else if (tick && tx_state != TX_IDLE) begin
				tx_ticks <= tx_ticks + 1'b1;
			end
		end
	end

	// fixed-width counter and mode, sampled per bit so a pulse never tears
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fix_cnt <= '0;
			fix_mode <= 1'b0;
		end else begin
			if (bit_start) begin
				fix_mode <= fixed_pulse; // R9
				fix_cnt <= '0;
			end else if (tx_state == TX_PULSE && !fixed_done) begin
				fix_cnt <= fix_cnt + 1'b1;
			end
		end
	end

	// output flops; idle level is low; R1 R12
	always_ff @(posedge clk) begin
		if (!nrst) begin
			light_pulse_out <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			light_pulse_out <= (next_tx_state == TX_PULSE); // R2 R13
			tx_ready <= tx_room;
		end
	end

	// ----------------------------------------
	// decoder
	// ----------------------------------------
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic rx_busy;
	logic [TW-1:0] rx_ticks;

	// pin crossing: two flops before any logic; R7 no phase relation
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_meta <= 1'b0;
			rx_sync <= 1'b0;
			rx_prev <= 1'b0;
		end else begin
			rx_meta <= light_pulse_in;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// each rising edge is one bit event, however long the pulse; R10
	wire rx_edge = rx_sync && !rx_prev;
	wire rx_last = tick && rx_ticks == TW'(TICKS_PER_BIT - 1);

	// stretch: hold low for sixteen ticks, retrigger on a new pulse; R3
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_busy <= 1'b0;
			rx_ticks <= '0;
		end else if (rx_edge) begin
			rx_busy <= 1'b1;
			rx_ticks <= '0;
		end else if (rx_busy && tick) begin
			rx_ticks <= rx_ticks + 1'b1;
			if (rx_last) begin
				rx_busy <= 1'b0;
			end
		end
	end

	// nrz is low for a stretched pulse, high at rest; R1 R12
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_nrz <= 1'b1;
			rx_valid <= 1'b0;
			rx_bit <= 1'b1;
		end else begin
			rx_nrz <= !(rx_edge || (rx_busy && !rx_last));
			rx_valid <= rx_edge; // R10
			rx_bit <= 1'b0; // R12
		end
	end
endmodule
`default_nettype wire

// File: tb/endec_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------
// endec port checks
// ------------------------
module endec_monitor #(
	parameter int TICK_DIV = 651,
	parameter int FIXED_PULSE_CYC = 160
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic light_pulse_out,
	input wire logic light_pulse_in,
	input wire logic rx_nrz,
	input wire logic rx_valid,
	input wire logic rx_bit
);
	localparam int BIT = 16 * TICK_DIV;
	logic [19:0] hi, gap, age;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// pulse length so far
	always_ff @(posedge clk) begin
		if (!nrst || !light_pulse_out) hi <= '0;
		else hi <= hi + 1'b1;
	end
	// saturate, so idle spans never wrap
	always_ff @(posedge clk) begin
		if (!nrst) gap <= '1;
		else if (light_pulse_out && hi == 0) gap <= '0;
		else if (gap != '1) gap <= gap + 1'b1;
	end
	// cycles since the last receive event
	always_ff @(posedge clk) begin
		if (!nrst) age <= '1;
		else if (rx_valid) age <= '0;
		else if (age != '1) age <= age + 1'b1;
	end
	property p_w;
		$fell(light_pulse_out) |-> hi == 3 * TICK_DIV || hi == FIXED_PULSE_CYC;
	endproperty
	a_w: assert property (p_w) else $error("pulse width");
	property p_gap; light_pulse_out && hi == 0 |-> gap >= BIT - 1; endproperty
	a_gap: assert property (p_gap) else $error("pulse spacing");
	property p_rxe; $rose(light_pulse_in) |-> ##[2:5] rx_valid; endproperty
	a_rxe: assert property (p_rxe) else $error("no rx event");
	property p_zero; rx_valid |-> !rx_bit && !rx_nrz; endproperty
	a_zero: assert property (p_zero) else $error("rx value");
	property p_one; rx_valid |=> !rx_valid; endproperty
	a_one: assert property (p_one) else $error("rx_valid long");
	property p_fall; $fell(rx_nrz) |-> rx_valid; endproperty
	a_fall: assert property (p_fall) else $error("stray fall");
	property p_hold; age < BIT - 2 * TICK_DIV |-> !rx_nrz; endproperty
	a_hold: assert property (p_hold) else $error("rx bit short");
	property p_end; age > BIT + TICK_DIV && !rx_valid |-> rx_nrz; endproperty
	a_end: assert property (p_end) else $error("rx bit long");
endmodule
bind infrared_pulse_endec endec_monitor #(
	.TICK_DIV(TICK_DIV),
	.FIXED_PULSE_CYC(FIXED_PULSE_CYC)
) u_endec_monitor (
	.clk(clk),
	.nrst(nrst),
	.light_pulse_out(light_pulse_out),
	.light_pulse_in(light_pulse_in),
	.rx_nrz(rx_nrz),
	.rx_valid(rx_valid),
	.rx_bit(rx_bit)
);
`default_nettype wire

// File: tb/ir_transceiver.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------
// transceiver model
// ------------------------
module ir_transceiver #(
	parameter int RX_WIDTH = 3
) (
	input wire logic clk,
	input wire logic light_pulse_out,
	input wire logic flash,
	output logic light_pulse_in,
	output int seen
);
	int left;
	logic led_q = 1'b0;
	// short fixed pulse per flash, whatever the light width
	always_ff @(posedge clk) begin
		if (flash) left <= RX_WIDTH;
		else if (left > 0) left <= left - 1;
	end
	assign light_pulse_in = left > 0;
	// each light pulse counted once
	always_ff @(posedge clk) begin
		led_q <= light_pulse_out;
		if (light_pulse_out && !led_q) seen <= seen + 1;
	end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------
// endec bench
// ------------------------
module testbench;
	localparam int TD = 4;
	localparam int BIT = 16 * TD;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_bit = 1'b1;
	logic fixed_pulse = 1'b0;
	logic flash = 1'b0;
	logic tx_ready, light_pulse_out, light_pulse_in, rx_nrz, rx_valid, rx_bit;
	int seen;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	infrared_pulse_endec #(.TICK_DIV(TD), .FIXED_PULSE_CYC(5))
		u_infrared_pulse_endec (
		.clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_bit(tx_bit), .fixed_pulse(fixed_pulse),
		.light_pulse_out(light_pulse_out), .light_pulse_in(light_pulse_in),
		.rx_nrz(rx_nrz), .rx_valid(rx_valid), .rx_bit(rx_bit));
	ir_transceiver u_ir_transceiver (.clk(clk), .flash(flash),
		.light_pulse_out(light_pulse_out), .light_pulse_in(light_pulse_in),
		.seen(seen));
	// 100 MHz
	initial begin
		forever #5 clk = ~clk;
	end
	task end_sim;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task ok(input logic c);
		n_checks++;
		if (c !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: check failed", $time);
		end
	endtask
	// hang guard, about six times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_sim();
		end
	end
	task wait_out(input logic lvl, output int n);
		for (n = 0; n < 3000 && light_pulse_out !== lvl; n++) @(posedge clk);
	endtask
	// valid stays up between back-to-back bits
	task push(input logic b);
		tx_valid <= 1'b1;
		tx_bit <= b;
		do @(posedge clk); while (tx_ready !== 1'b1);
	endtask
	task t_tx;
		int s0, w;
		logic [3:0] pat;
		s0 = seen;
		pat = 4'h2;
		for (int i = 0; i < 4; i++) push(pat[i]);
		tx_valid <= 1'b0;
		repeat (2) begin
			wait_out(1'b1, w);
			wait_out(1'b0, w);
		end
		ok(w == 3 * TD);
		repeat (5 * BIT) @(posedge clk);
		ok(seen - s0 == 3);
	endtask
	task t_fixed;
		int w;
		fixed_pulse <= 1'b1;
		push(1'b0);
		tx_valid <= 1'b0;
		wait_out(1'b1, w);
		wait_out(1'b0, w);
		ok(w == 5);
		fixed_pulse <= 1'b0;
	endtask
	task t_rx;
		int k, w, n;
		flash <= 1'b1;
		@(posedge clk);
		flash <= 1'b0;
		for (k = 0; k < 10 && rx_valid !== 1'b1; k++) @(posedge clk);
		ok(rx_bit === 1'b0 && rx_nrz === 1'b0);
		for (w = 0; w < 200 && rx_nrz !== 1'b1; w++) @(posedge clk);
		ok(w >= BIT - 2 * TD && w <= BIT + TD);
		n = 0;
		for (k = 0; k < 3 * BIT; k++) begin
			flash <= (k == 0 || k == 20);
			@(posedge clk);
			n += (rx_valid === 1'b1);
		end
		ok(n == 2);
	endtask
	// fill until refused: 32 slots plus at most two pops in 100 cycles
	task t_fill;
		int w, acc;
		acc = 0;
		tx_valid <= 1'b1;
		tx_bit <= 1'b1;
		repeat (100) begin
			@(posedge clk);
			acc += (tx_ready === 1'b1);
		end
		tx_valid <= 1'b0;
		ok(acc >= 32 && acc <= 34);
		repeat (40 * BIT) @(posedge clk);
		push(1'b0);
		tx_valid <= 1'b0;
		wait_out(1'b1, w);
		ok(w < BIT);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_tx();
		t_fixed();
		t_rx();
		t_fill();
		end_sim();
	end
endmodule
`default_nettype wire
